// *** sci_status_data_baud.sv ***
`timescale 1ns/100ps
`include "sci_regs.svh"

// Overview of operation
// - Handoff sets tx empty; status read, write clears
// - Tx empty with enable raises tx request
// - Done flag when empty and nothing shifting
// - Queued data, preamble or break clear done
// - Done flag with enable raises tx request
// - Char load sets rx full; read pair clears
// - Rx full with enable raises rx request
// - Ten or eleven ones set line quiet
// - Quiet detection armed only after valid char
// - Line quiet with enable raises rx request
// - Char while full sets overrun, drops char
// - Overrun clears only if seen at status read
// - Noise sets flag, error request, read pair clears
// - Zero stop bit sets framing flag
// - Parity mismatch sets parity flag
// - Break sets break, framing, full; clears ninth in nine-bit mode
// - Break clears by read pair, rearms after ones
// - Start zero sets active; false start clears
// - Data buffer reads rx byte, writes tx
// - Prescale codes divide by 1, 3, 4, 13
// - Rate codes divide by two to code
// - Baud equals bus over 64 PD BD
// - Interrupt enables read/write, reset cleared
module sci_status_data_baud (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Receive pin
  input wire logic rxd,
  // Receiver events
  input wire logic rx_enable,
  input wire logic nine_bit_mode,
  input wire logic rx_char_done,
  input wire logic [7:0] rx_char,
  input wire logic rx_char_ninth,
  input wire logic rx_noise,
  input wire logic rx_frame_err,
  input wire logic rx_parity_err,
  input wire logic rx_break,
  input wire logic rx_start_low,
  input wire logic rx_false_start,
  // Transmitter handoff
  input wire logic tx_take,
  input wire logic tx_busy,
  input wire logic tx_queue,
  output logic [7:0] tx_data,
  output logic tx_data_valid,
  // Divider chain ticks
  output logic sample_tick,
  output logic bit_tick,
  // Flags to other blocks
  output logic rx_ninth_bit,
  // Interrupt requests
  output logic tx_irq,
  output logic rx_irq,
  output logic err_irq
);

  // Whole-block reset image. The data bytes are cleared too, because the
  // reset branch may only load constants; software must treat them as
  // undefined after reset.
  localparam sci_pkg::sci_state_t RESET_STATE = '{
    bus: sci_pkg::BUS_IDLE,
    addr: 8'h00,
    wr: 1'h0,
    rdata: 32'h00000000,
    rx_buf: 8'h00,
    tx_buf: 8'h00,
    ninth: 1'h0,
    status1: `RST_STATUS_PRIMARY,
    brk: 1'h0,
    rx_active: 1'h0,
    arm1: 8'h00,
    arm_brk: 1'h0,
    irq_en: `RST_IRQ_ENABLE,
    pre_sel: 2'h0,
    rate_sel: 3'h0,
    div_cnt: 13'h0000,
    phase_cnt: 4'h0,
    ones_cnt: 4'h0,
    idle_armed: 1'h0,
    brk_allow: 1'h1,
    rxd_meta: 1'h1,
    rxd_sync: 1'h1
  };

  // Prescaler divisor for the two-bit code
  function automatic logic [3:0] prescale_div(input logic [1:0] code);
    unique case (code)
      2'h0: prescale_div = 4'h1;
      2'h1: prescale_div = 4'h3;
      2'h2: prescale_div = 4'h4;
      2'h3: prescale_div = 4'hd;
    endcase
  endfunction

  // Bus clocks per receiver sample: 4 x PD x BD, never above 6656
  function automatic logic [12:0] sample_period(
    input logic [1:0] pre,
    input logic [2:0] rate
  );
    logic [12:0] scaled;
    scaled = `SAMPLE_BASE_DIV * {9'h000, prescale_div(pre)};
    sample_period = scaled << rate;
  endfunction

  // Register decode, shared by every access strobe
  function automatic logic reg_hit(
    input logic [7:0] a,
    input logic [7:0] off
  );
    reg_hit = (a == off);
  endfunction

  sci_pkg::sci_state_t state;
  sci_pkg::sci_state_t next_state;
  logic addr_phase;
  logic data_phase;
  logic status1_rd;
  logic status2_rd;
  logic data_rd;
  logic data_wr;
  logic rate_wr;
  logic irq_wr;
  logic [7:0] read_clear;

  // Bus strobes
  assign addr_phase = hsel && hready && htrans[1];
  assign data_phase = (state.bus == sci_pkg::BUS_BUSY);
  assign status1_rd = data_phase && !state.wr
    && reg_hit(state.addr, `OFF_STATUS_PRIMARY);
  assign status2_rd = data_phase && !state.wr
    && reg_hit(state.addr, `OFF_STATUS_SECONDARY);
  assign data_rd = data_phase && !state.wr
    && reg_hit(state.addr, `OFF_DATA_BUFFER);
  assign data_wr = data_phase && state.wr
    && reg_hit(state.addr, `OFF_DATA_BUFFER);
  assign rate_wr = data_phase && state.wr
    && reg_hit(state.addr, `OFF_RATE_SELECT);
  assign irq_wr = data_phase && state.wr
    && reg_hit(state.addr, `OFF_IRQ_ENABLE);

  // Receive flags clear only when armed by an earlier status read
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_clear
      assign read_clear[gi] = data_rd && state.arm1[gi];
    end
  endgenerate
  // Transmit flags never clear on a data read
  assign read_clear[7:6] = 2'h0;

  always_comb
  begin
    logic [12:0] period;
    logic [3:0] quiet_len;
    logic quiet_hit;
    logic full_now;
    period = sample_period(state.pre_sel, state.rate_sel);
    quiet_len = nine_bit_mode ? `IDLE_ONES_LONG : `IDLE_ONES_SHORT;
    quiet_hit = bit_tick && state.rxd_sync
      && (state.ones_cnt == quiet_len - 4'h1);
    full_now = 1'h0;
    next_state = state;

    // Pin synchroniser; only the second stage feeds logic
    next_state.rxd_meta = rxd;
    next_state.rxd_sync = state.rxd_meta;

    // Bus: one wait state, so a read sees flags after all updates
    unique case (state.bus)
      sci_pkg::BUS_IDLE, sci_pkg::BUS_DONE:
      begin
        if (addr_phase)
        begin
          next_state.bus = sci_pkg::BUS_BUSY;
          next_state.addr = haddr[7:0];
          next_state.wr = hwrite;
        end
        else
        begin
          next_state.bus = sci_pkg::BUS_IDLE;
        end
      end
      sci_pkg::BUS_BUSY:
      begin
        next_state.bus = sci_pkg::BUS_DONE;
        next_state.rdata = 32'h00000000;
        if (!state.wr)
        begin
          case (state.addr)
            `OFF_STATUS_PRIMARY:
            begin
              next_state.rdata = {24'h000000, state.status1};
            end
            `OFF_STATUS_SECONDARY:
            begin
              next_state.rdata = {30'h00000000, state.brk, state.rx_active};
            end
            `OFF_DATA_BUFFER:
            begin
              next_state.rdata = {24'h000000, state.rx_buf};
            end
            `OFF_RATE_SELECT:
            begin
              next_state.rdata = {24'h000000, 2'h0, state.pre_sel, 1'h0,
                state.rate_sel};
            end
            `OFF_IRQ_ENABLE:
            begin
              next_state.rdata = {24'h000000, state.irq_en};
            end
            default:
            begin
              next_state.rdata = 32'h00000000;
            end
          endcase
        end
      end
      default:
      begin
        next_state.bus = sci_pkg::BUS_IDLE;
      end
    endcase

    // A status read arms exactly the flags it showed set
    if (status1_rd)
    begin
      next_state.arm1 = state.status1;
    end
    if (status2_rd)
    begin
      next_state.arm_brk = state.brk;
    end

    // Data read: clear armed receive flags, then disarm
    if (data_rd)
    begin
      next_state.status1 = state.status1 & ~read_clear;
      next_state.arm1[5:0] = 6'h00;
      if (state.arm_brk)
      begin
        next_state.brk = 1'h0;
      end
      next_state.arm_brk = 1'h0;
    end

    // Transmit buffer and its empty flag
    if (data_wr)
    begin
      next_state.tx_buf = hwdata[7:0];
      if (state.arm1[`BIT_TX_EMPTY])
      begin
        next_state.status1[`BIT_TX_EMPTY] = 1'h0;
      end
      next_state.arm1[`BIT_TX_EMPTY] = 1'h0;
    end
    // Handoff wins over a write in the same cycle
    if (tx_take)
    begin
      next_state.status1[`BIT_TX_EMPTY] = 1'h1;
    end

    // Queueing wins so a preamble queued while idle drops the flag
    if (tx_queue)
    begin
      next_state.status1[`BIT_TX_DONE] = 1'h0;
    end
    else if (state.status1[`BIT_TX_EMPTY] && !tx_busy)
    begin
      next_state.status1[`BIT_TX_DONE] = 1'h1;
    end

    // Consecutive ones on the line, counted in bit times
    if (!state.rxd_sync)
    begin
      next_state.ones_cnt = 4'h0;
    end
    else if (bit_tick && (state.ones_cnt < quiet_len))
    begin
      next_state.ones_cnt = state.ones_cnt + 4'h1;
    end
    if (!rx_enable)
    begin
      next_state.idle_armed = 1'h0;
    end
    if (quiet_hit && state.idle_armed)
    begin
      next_state.status1[`BIT_LINE_QUIET] = 1'h1;
      next_state.idle_armed = 1'h0;
    end

    // Reception in progress: a new start wins over a clear
    if (rx_false_start || quiet_hit)
    begin
      next_state.rx_active = 1'h0;
    end
    if (rx_start_low)
    begin
      next_state.rx_active = 1'h1;
    end

    // A read that empties the buffer this cycle lets a new byte in
    full_now = next_state.status1[`BIT_RX_FULL];
    if (rx_char_done)
    begin
      if (full_now)
      begin
        next_state.status1[`BIT_OVERRUN] = 1'h1;
      end
      else
      begin
        next_state.rx_buf = rx_char;
        next_state.ninth = nine_bit_mode ? rx_char_ninth : rx_char[7];
        next_state.status1[`BIT_RX_FULL] = 1'h1;
        next_state.idle_armed = rx_enable;
      end
    end

    // Error flags: events win over a clear in the same cycle
    if (rx_noise)
    begin
      next_state.status1[`BIT_NOISE] = 1'h1;
    end
    if (rx_frame_err)
    begin
      next_state.status1[`BIT_FRAMING] = 1'h1;
    end
    if (rx_parity_err)
    begin
      next_state.status1[`BIT_PARITY] = 1'h1;
    end

    // Break: flag only once per stretch of ones on the line
    if (rx_break)
    begin
      next_state.status1[`BIT_FRAMING] = 1'h1;
      next_state.status1[`BIT_RX_FULL] = 1'h1;
      if (nine_bit_mode)
      begin
        next_state.ninth = 1'h0;
      end
      if (state.brk_allow)
      begin
        next_state.brk = 1'h1;
      end
      next_state.brk_allow = 1'h0;
    end
    else if (state.rxd_sync)
    begin
      next_state.brk_allow = 1'h1;
    end

    // Software registers
    if (rate_wr)
    begin
      next_state.pre_sel = hwdata[`RATE_PRESCALE_LSB +: 2];
      next_state.rate_sel = hwdata[`RATE_DIVISOR_LSB +: 3];
    end
    if (irq_wr)
    begin
      next_state.irq_en = hwdata[7:0];
    end

    // Divider chain; a new rate takes effect at the next sample
    if (state.div_cnt == 13'h0000)
    begin
      next_state.div_cnt = period - 13'h0001;
      if (state.phase_cnt == `SAMPLES_PER_BIT)
      begin
        next_state.phase_cnt = 4'h0;
      end
      else
      begin
        next_state.phase_cnt = state.phase_cnt + 4'h1;
      end
    end
    else
    begin
      next_state.div_cnt = state.div_cnt - 13'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= RESET_STATE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Bus outputs; every response is OKAY
  assign hreadyout = (state.bus != sci_pkg::BUS_BUSY);
  assign hresp = 1'h0;
  assign hrdata = state.rdata;

  // Transmitter handoff: data waits while the empty flag is clear
  assign tx_data = state.tx_buf;
  assign tx_data_valid = !state.status1[`BIT_TX_EMPTY];

  // Divider ticks
  assign sample_tick = (state.div_cnt == 13'h0000);
  assign bit_tick = sample_tick
    && (state.phase_cnt == `SAMPLES_PER_BIT);

  assign rx_ninth_bit = state.ninth;

  // Requests; break and reception-in-progress never request
  assign tx_irq = (state.status1[`BIT_TX_EMPTY]
    && state.irq_en[`BIT_TX_EMPTY])
    || (state.status1[`BIT_TX_DONE] && state.irq_en[`BIT_TX_DONE]);
  assign rx_irq = (state.status1[`BIT_RX_FULL]
    && state.irq_en[`BIT_RX_FULL])
    || (state.status1[`BIT_LINE_QUIET]
    && state.irq_en[`BIT_LINE_QUIET]);
  assign err_irq = |(state.status1[3:0] & state.irq_en[3:0]);

endmodule

// *** sci_regs.svh ***
`ifndef SCI_REGS_SVH
`define SCI_REGS_SVH

// Byte addresses on the register bus
`define OFF_STATUS_PRIMARY 8'h10
`define OFF_STATUS_SECONDARY 8'h14
`define OFF_DATA_BUFFER 8'h18
`define OFF_RATE_SELECT 8'h1c
`define OFF_IRQ_ENABLE 8'h20

// Primary status and interrupt enable bit positions
`define BIT_TX_EMPTY 7
`define BIT_TX_DONE 6
`define BIT_RX_FULL 5
`define BIT_LINE_QUIET 4
`define BIT_OVERRUN 3
`define BIT_NOISE 2
`define BIT_FRAMING 1
`define BIT_PARITY 0

// Secondary status bit positions
`define BIT_BREAK 1
`define BIT_RX_ACTIVE 0

// Rate select field positions
`define RATE_PRESCALE_LSB 4
`define RATE_DIVISOR_LSB 0

// Reset values
`define RST_STATUS_PRIMARY 8'hc0
`define RST_RATE_SELECT 8'h00
`define RST_IRQ_ENABLE 8'h00

// Flags cleared by a status read then a data buffer read
`define READ_CLEAR_MASK 8'h3f

// Divider chain: bus clocks per sample at unit divisors, last sample index in a bit
`define SAMPLE_BASE_DIV 13'h0004
`define SAMPLES_PER_BIT 4'hf
`define IDLE_ONES_SHORT 4'ha
`define IDLE_ONES_LONG 4'hb

`endif

// *** sci_pkg.sv ***
package sci_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_BUSY,
    BUS_DONE
  } bus_state_t;

  typedef struct packed {
    bus_state_t bus;
    logic [7:0] addr;
    logic wr;
    logic [31:0] rdata;
    logic [7:0] rx_buf;
    logic [7:0] tx_buf;
    logic ninth;
    logic [7:0] status1;
    logic brk;
    logic rx_active;
    logic [7:0] arm1;
    logic arm_brk;
    logic [7:0] irq_en;
    logic [1:0] pre_sel;
    logic [2:0] rate_sel;
    logic [12:0] div_cnt;
    logic [3:0] phase_cnt;
    logic [3:0] ones_cnt;
    logic idle_armed;
    logic brk_allow;
    logic rxd_meta;
    logic rxd_sync;
  } sci_state_t;

endpackage

// *** sci_checker.sv ***
`timescale 1ns/100ps
module sci_checker (
  input wire logic hclk, hresetn, hreadyout, hresp, rxd, rx_char_done,
  input wire logic rx_break, nine_bit_mode, rx_ninth_bit,
  input wire logic sample_tick, bit_tick, tx_irq, rx_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (!hresp) else $error("resp");
  a_ready_back: assert property (!hreadyout |-> ##[1:8] hreadyout)
    else $error("stall");
  // Fastest chain is four clocks a sample, sixteen samples a bit
  a_sample_gap: assert property (sample_tick |=> !sample_tick [*3])
    else $error("sample");
  a_bit_gap: assert property (bit_tick |=> !bit_tick [*8])
    else $error("bit");
  a_tx_irq_reset: assert property ($rose(hresetn) |-> !tx_irq)
    else $error("tx irq");
  a_rx_irq_reset: assert property ($rose(hresetn) |-> !rx_irq)
    else $error("rx irq");
  a_ninth_break: assert property (rx_break && nine_bit_mode |=>
    !rx_ninth_bit) else $error("ninth");
  a_rx_irq_src: assert property ($rose(rx_irq) |-> $past(rx_char_done)
    || $past(rx_break) || $past(!hreadyout) || $past(bit_tick))
    else $error("rx src");
  c_rx: cover property (rx_irq);
  c_tx: cover property (tx_irq);
  c_bit: cover property (bit_tick);
endmodule

bind sci_status_data_baud sci_checker u_chk (.*);

// *** sci_remote.sv ***
`timescale 1ns/100ps
module sci_remote (
  input wire logic hclk,
  output logic rxd, rx_char_done, rx_break, nine_bit_mode,
  output logic [7:0] rx_char
);
  initial {rxd, rx_char_done, rx_break, nine_bit_mode, rx_char} = 12'h800;
  task automatic send(input logic [7:0] b);
    @(posedge hclk);
    rxd <= 1'b0;
    rx_char <= b;
    rx_char_done <= 1'b1;
    @(posedge hclk);
    rx_char_done <= 1'b0;
    rx_char <= ~b;
    rxd <= 1'b1;
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hresp, hreadyout;
  logic rx_enable = 1, rx_char_ninth = 0, rx_noise = 0, rx_frame_err = 0;
  logic rx_parity_err = 0, rx_start_low = 0, rx_false_start = 0, tx_take = 0;
  logic tx_busy = 0, tx_queue = 0, tx_data_valid, sample_tick, bit_tick;
  logic rx_ninth_bit, tx_irq, rx_irq, err_irq;
  logic rxd, rx_char_done, rx_break, nine_bit_mode;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] rx_char, tx_data, b;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
  wire hready = hreadyout;
  int n_fail = 0, checks = 0, seed = 93, n = 0;
  sci_status_data_baud u_dut (.*);
  sci_remote u_far (.*);
  initial forever #50 hclk = ~hclk;
  task conclude;
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic wt;
    int i = 0;
    do @(posedge hclk); while (hready !== 1'b1 && ++i < 99);
    if (i == 99) n_fail++;
    if (i == 99) conclude;
  endtask
  function automatic int bit_period(input logic [7:0] r);
    int pd;
    pd = (r[5:4] == 2'h3) ? 13 : (r[5:4] == 2'h2) ? 4 : (r[5:4] == 2'h1) ? 3 : 1;
    return 64 * pd * (1 << r[2:0]);
  endfunction
  task automatic tick(output int k);
    k = 0;
    do @(posedge hclk); while (bit_tick !== 1'b1 && ++k < 9000);
    if (k == 9000) n_fail++;
    if (k == 9000) conclude;
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wt;
    htrans <= 2'h0;
    hwdata <= v;
    wt;
    d = hrdata;
  endtask
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, 8'h10, 0);
    chk(d, 32'hc0);
    repeat (3)
    begin
      b = $random(seed);
      xfer(1, 8'h1c, b & 8'h33);
      xfer(0, 8'h1c, 0);
      chk(d, b & 8'h33);
      tick(n);
      tick(n);
      chk(n + 1, bit_period(b & 8'h33));
      xfer(1, 8'h20, 32'ha8);
      u_far.send(b);
      u_far.send(~b);
      repeat (3) @(posedge hclk);
      chk({tx_irq, rx_irq, err_irq}, 3'h7);
      xfer(0, 8'h10, 0);
      chk(d & 8'h28, 32'h28);
      xfer(0, 8'h18, 0);
      chk(d, b);
      chk(rx_ninth_bit, b[7]);
      xfer(0, 8'h10, 0);
      chk(d & 8'h28, 0);
      xfer(1, 8'h18, b ^ 8'h5a);
      chk({tx_data_valid, tx_data}, {1'h1, b ^ 8'h5a});
      chk(tx_irq, 0);
      tx_take <= 1'h1;
      @(posedge hclk);
      tx_take <= 1'h0;
      @(posedge hclk);
      chk(tx_irq, 1);
    end
    conclude;
  end
endmodule
